//--- include/tcp_pkg.sv
// Constants, types and register map of the triple counter pacer
package tcp_pkg;

    // System clock and fixed internal counting source
    localparam int CLK_HZ         = 50_000_000;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int INT_CLK_HZ     = 2_000_000;
    localparam int INT_DIV        = CLK_HZ / INT_CLK_HZ;
    localparam int INT_DIV_W      = 5;
    localparam logic [INT_DIV_W-1:0] INT_DIV_LAST =
        INT_DIV_W'(INT_DIV - 1);
    localparam logic [INT_DIV_W-1:0] RST_DIV_CNT  = 5'h00;

    // Fastest external counting clock, 5 MHz
    localparam int EXT_CLK_MIN_NS  = 200;
    localparam int EXT_CLK_MIN_CYC =
        (EXT_CLK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int NUM_CNT  = 3;
    localparam int NUM_PINS = 4;

    // Byte offsets of the four I/O locations
    localparam logic [1:0] OFS_CNT0 = 2'h0;
    localparam logic [1:0] OFS_CNT1 = 2'h1;
    localparam logic [1:0] OFS_CNT2 = 2'h2;
    localparam logic [1:0] OFS_CTRL = 2'h3;

    // Control word fields
    localparam int CW_SEL_LO  = 6;
    localparam int CW_RW_LO   = 4;
    localparam int CW_MODE_LO = 1;
    localparam int CW_BCD     = 0;
    localparam logic [1:0] SEL_READBACK = 2'h3;

    // Read/write access formats
    localparam logic [1:0] RW_LATCH = 2'h0;
    localparam logic [1:0] RW_LSB   = 2'h1;
    localparam logic [1:0] RW_MSB   = 2'h2;
    localparam logic [1:0] RW_BOTH  = 2'h3;

    typedef enum logic [2:0] {
        MODE0 = 3'h0,
        MODE1 = 3'h1,
        MODE2 = 3'h2,
        MODE3 = 3'h3,
        MODE4 = 3'h4,
        MODE5 = 3'h5
    } cnt_mode_e;

    // Values after reset, and what a read of the control location returns
    localparam cnt_mode_e   RST_MODE  = MODE0;
    localparam logic [1:0]  RST_RWM   = RW_BOTH;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [7:0]  RST_RDATA = 8'h00;
    localparam logic [7:0]  CTRL_READ = 8'h00;

    typedef struct packed {
        cnt_mode_e [NUM_CNT-1:0]        mode;
        logic [NUM_CNT-1:0][1:0]        rwm;
        logic [NUM_CNT-1:0]             bcd;
        logic [NUM_CNT-1:0][15:0]       cr;
        logic [NUM_CNT-1:0][15:0]       ce;
        logic [NUM_CNT-1:0][15:0]       ol;
        logic [NUM_CNT-1:0]             latched;
        logic [NUM_CNT-1:0]             wr_hi;
        logic [NUM_CNT-1:0]             rd_hi;
        logic [NUM_CNT-1:0]             load_pend;
        logic [NUM_CNT-1:0]             trig;
        logic [NUM_CNT-1:0]             armed;
        logic [NUM_CNT-1:0]             run;
        logic [NUM_CNT-1:0]             out;
        logic [NUM_CNT-1:0]             out_prev;
        logic [7:0]                     rdata;
        logic                           adc_trig;
    } pacer_s;

endpackage

//--- include/timer_pins_if.sv
// Raw and synchronised timer pins shared between top and synchroniser
`timescale 1ns/10ps
`default_nettype none
interface timer_pins_if;
    import tcp_pkg::*;
    logic [NUM_PINS-1:0] raw;
    logic [NUM_PINS-1:0] level;
    logic [NUM_PINS-1:0] rise;
    logic [NUM_PINS-1:0] fall;
    modport sync (input raw, output level, output rise, output fall);
    modport user (output raw, input level, input rise, input fall);
endinterface
`default_nettype wire

//--- src/int_clk_div.sv
// Divider that makes the 2 MHz internal counting tick
`timescale 1ns/10ps
`default_nettype none
module int_clk_div
    import tcp_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    input  wire logic    i_ce,
    output logic         o_tick
);
    typedef struct packed {
        logic [INT_DIV_W-1:0] cnt;
        logic                 tick;
    } div_s;

    div_s q;
    div_s d;

    always_comb
    begin
        d      = q;
        d.tick = (q.cnt == INT_DIV_LAST);
        d.cnt  = d.tick ? RST_DIV_CNT : q.cnt + 5'h01;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    assign o_tick = q.tick;

    property p_tick_gap;
        @(posedge i_clk) disable iff (!i_rst_n || !i_ce)
        o_tick |=> (!o_tick)[*8] ##1 (!o_tick)[*8] ##1 (!o_tick)[*8]
                   ##1 o_tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("bad tick gap");
endmodule
`default_nettype wire

//--- src/pin_sync.sv
// Two-flop synchroniser with edge detection for the timer pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync
    import tcp_pkg::*;
(
    input  wire logic    i_clk,
    input  wire logic    i_rst_n,
    input  wire logic    i_ce,
    timer_pins_if.sync   pins
);
    typedef struct packed {
        logic [NUM_PINS-1:0] s1;
        logic [NUM_PINS-1:0] s2;
        logic [NUM_PINS-1:0] s3;
    } sync_s;

    sync_s q;
    sync_s d;

    always_comb
    begin
        d    = q;
        d.s1 = pins.raw;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            q <= '0;
        else if (i_ce)
            q <= d;
    end

    // Edges compare stages two and three only
    assign pins.level = q.s2;
    assign pins.rise  = q.s2 & ~q.s3;
    assign pins.fall  = ~q.s2 & q.s3;
endmodule
`default_nettype wire

//--- src/triple_counter_pacer.sv
// Three 16-bit down counters with cascaded A/D pacer on a byte port
`timescale 1ns/10ps
`default_nettype none
module triple_counter_pacer
    import tcp_pkg::*;
(
    input  wire logic                i_clk,
    input  wire logic                i_rst_n,
    input  wire logic                i_ce,
    input  wire logic [1:0]          i_addr,
    input  wire logic                i_wr,
    input  wire logic                i_rd,
    input  wire logic [7:0]          i_wdata,
    output logic      [7:0]          o_rdata,
    input  wire logic                i_clk0_ext_sel,
    input  wire logic                i_ext_clk0,
    input  wire logic [NUM_CNT-1:0]  i_gate,
    input  wire logic                i_pacer_int_sel,
    output logic      [NUM_CNT-1:0]  o_timer_out,
    output logic                     o_adc_trig
);
    pacer_s              q;
    pacer_s              d;
    logic                int_tick;
    logic [NUM_CNT-1:0]  tick;
    logic [NUM_CNT-1:0]  gate_lvl;
    logic [NUM_CNT-1:0]  gate_rise;

    timer_pins_if pins ();

    assign pins.raw = {i_gate, i_ext_clk0};

    pin_sync u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .pins    (pins)
    );

    int_clk_div u_div (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_ce    (i_ce),
        .o_tick  (int_tick)
    );

    assign gate_lvl  = pins.level[NUM_PINS-1:1];
    assign gate_rise = pins.rise[NUM_PINS-1:1];

    // Counting happens on the falling edge of each counter's clock
    assign tick[0] = i_clk0_ext_sel ? pins.fall[0] : int_tick;
    assign tick[1] = int_tick;
    assign tick[2] = q.out_prev[1] & ~q.out[1];

    function automatic logic [15:0] dec16(input logic [15:0] v,
                                          input logic        bcd);
        logic [15:0] r;
        logic        brw;
        r   = v - 16'h0001;
        brw = 1'b1;
        if (bcd)
        begin
            r = v;
            for (int k = 0; k < 4; k++)
            begin
                if (brw)
                begin
                    if (v[4*k +: 4] == 4'h0)
                        r[4*k +: 4] = 4'h9;
                    else
                    begin
                        r[4*k +: 4] = v[4*k +: 4] - 4'h1;
                        brw         = 1'b0;
                    end
                end
            end
        end
        return r;
    endfunction

    always_comb
    begin
        logic [15:0] nx;
        logic [15:0] rv;
        logic [15:0] hv;
        logic [1:0]  ch;
        logic [2:0]  wm;
        logic        done;
        nx   = RST_COUNT;
        rv   = RST_COUNT;
        hv   = RST_COUNT;
        ch   = i_wdata[CW_SEL_LO +: 2];
        wm   = i_wdata[CW_MODE_LO +: 3];
        done = 1'b0;
        d    = q;
        d.adc_trig = q.out_prev[2] & ~q.out[2] & i_pacer_int_sel;
        for (int i = 0; i < NUM_CNT; i++)
        begin
            d.out_prev[i] = q.out[i];
            nx = dec16(q.ce[i], q.bcd[i]);
            hv = {q.cr[i][15:1], 1'b0};
            if (!gate_lvl[i] &&
                (q.mode[i] == MODE2 || q.mode[i] == MODE3))
                d.out[i] = 1'b1;
            if (tick[i])
            begin
                unique case (q.mode[i])
                    MODE0:
                    begin
                        if (q.load_pend[i])
                        begin
                            d.ce[i]        = q.cr[i];
                            d.load_pend[i] = 1'b0;
                            d.run[i]       = 1'b1;
                        end
                        else if (q.run[i] && gate_lvl[i])
                        begin
                            d.ce[i] = nx;
                            if (nx == RST_COUNT)
                                d.out[i] = 1'b1;
                        end
                    end
                    MODE1, MODE5:
                    begin
                        if (q.trig[i])
                        begin
                            d.ce[i]    = q.cr[i];
                            d.trig[i]  = 1'b0;
                            d.armed[i] = 1'b1;
                            d.out[i]   = (q.mode[i] == MODE5);
                        end
                        else
                        begin
                            d.ce[i] = nx;
                            if (q.armed[i] && nx == RST_COUNT)
                            begin
                                d.armed[i] = 1'b0;
                                d.out[i]   = (q.mode[i] == MODE1);
                            end
                            else if (q.mode[i] == MODE5)
                                d.out[i] = 1'b1;
                        end
                    end
                    MODE2:
                    begin
                        if (q.load_pend[i] || q.trig[i])
                        begin
                            d.ce[i]        = q.cr[i];
                            d.load_pend[i] = 1'b0;
                            d.trig[i]      = 1'b0;
                            d.run[i]       = 1'b1;
                            d.out[i]       = 1'b1;
                        end
                        else if (q.run[i] && gate_lvl[i])
                        begin
                            // Zero reloads as 65536 through the wrap
                            if (q.ce[i] == 16'h0001)
                            begin
                                d.ce[i]  = q.cr[i];
                                d.out[i] = 1'b1;
                            end
                            else
                            begin
                                d.ce[i]  = nx;
                                d.out[i] = (nx != 16'h0001);
                            end
                        end
                    end
                    MODE3:
                    begin
                        // Odd counts stay high one tick longer
                        rv = (q.cr[i][0] && !q.out[i]) ? hv + 16'h0002
                                                        : hv;
                        if (q.load_pend[i] || q.trig[i])
                        begin
                            d.ce[i]        = q.cr[i][0] ? hv + 16'h0002
                                                        : hv;
                            d.load_pend[i] = 1'b0;
                            d.trig[i]      = 1'b0;
                            d.run[i]       = 1'b1;
                            d.out[i]       = 1'b1;
                        end
                        else if (q.run[i] && gate_lvl[i])
                        begin
                            if (q.ce[i] == 16'h0002)
                            begin
                                d.ce[i]  = rv;
                                d.out[i] = ~q.out[i];
                            end
                            else
                                d.ce[i] = q.ce[i] - 16'h0002;
                        end
                    end
                    MODE4:
                    begin
                        if (q.load_pend[i])
                        begin
                            d.ce[i]        = q.cr[i];
                            d.load_pend[i] = 1'b0;
                            d.run[i]       = 1'b1;
                            d.armed[i]     = 1'b1;
                            d.out[i]       = 1'b1;
                        end
                        else if (q.run[i] && gate_lvl[i])
                        begin
                            d.ce[i]  = nx;
                            d.out[i] = !(q.armed[i] && nx == RST_COUNT);
                            if (nx == RST_COUNT)
                                d.armed[i] = 1'b0;
                        end
                    end
                    default:
                    begin
                        d.mode[i] = RST_MODE;
                    end
                endcase
            end
            // After the tick, so the tick's clear of trig never drops a fresh gate edge
            if (gate_rise[i] && (q.run[i] || q.load_pend[i]))
                d.trig[i] = 1'b1;
        end
        // Host access after counting, so a write wins over a tick
        if (i_wr && i_addr == OFS_CTRL && ch != SEL_READBACK)
        begin
            if (i_wdata[CW_RW_LO +: 2] == RW_LATCH)
            begin
                if (!q.latched[ch])
                begin
                    d.ol[ch]      = q.ce[ch];
                    d.latched[ch] = 1'b1;
                end
            end
            else
            begin
                d.mode[ch]      = wm[1] ? cnt_mode_e'({1'b0, wm[1:0]})
                                        : cnt_mode_e'(wm);
                d.rwm[ch]       = i_wdata[CW_RW_LO +: 2];
                d.bcd[ch]       = i_wdata[CW_BCD];
                d.out[ch]       = (wm != 3'h0);
                d.wr_hi[ch]     = 1'b0;
                d.rd_hi[ch]     = 1'b0;
                d.latched[ch]   = 1'b0;
                d.load_pend[ch] = 1'b0;
                d.trig[ch]      = 1'b0;
                d.armed[ch]     = 1'b0;
                d.run[ch]       = 1'b0;
            end
        end
        else if (i_wr && i_addr != OFS_CTRL)
        begin
            unique case (q.rwm[i_addr])
                RW_LSB:
                begin
                    d.cr[i_addr] = {8'h00, i_wdata};
                    done         = 1'b1;
                end
                RW_MSB:
                begin
                    d.cr[i_addr] = {i_wdata, 8'h00};
                    done         = 1'b1;
                end
                default:
                begin
                    if (!q.wr_hi[i_addr])
                        d.cr[i_addr][7:0] = i_wdata;
                    else
                        d.cr[i_addr][15:8] = i_wdata;
                    done            = q.wr_hi[i_addr];
                    d.wr_hi[i_addr] = ~q.wr_hi[i_addr];
                end
            endcase
            if (done)
            begin
                d.load_pend[i_addr] = 1'b1;
                if (q.mode[i_addr] == MODE0)
                begin
                    d.out[i_addr] = 1'b0;
                    d.run[i_addr] = 1'b0;
                end
                if (q.mode[i_addr] == MODE1 || q.mode[i_addr] == MODE5)
                    d.run[i_addr] = 1'b1;
            end
        end
        if (i_rd)
        begin
            d.rdata = CTRL_READ;
            if (i_addr != OFS_CTRL)
            begin
                nx = q.latched[i_addr] ? q.ol[i_addr] : q.ce[i_addr];
                unique case (q.rwm[i_addr])
                    RW_LSB:
                    begin
                        d.rdata = nx[7:0];
                        if (q.latched[i_addr])
                            d.latched[i_addr] = 1'b0;
                    end
                    RW_MSB:
                    begin
                        d.rdata = nx[15:8];
                        if (q.latched[i_addr])
                            d.latched[i_addr] = 1'b0;
                    end
                    default:
                    begin
                        d.rdata = q.rd_hi[i_addr] ? nx[15:8] : nx[7:0];
                        d.rd_hi[i_addr] = ~q.rd_hi[i_addr];
                        if (q.rd_hi[i_addr] && q.latched[i_addr])
                            d.latched[i_addr] = 1'b0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            q       <= '0;
            q.mode  <= '{default: RST_MODE};
            q.rwm   <= {NUM_CNT{RST_RWM}};
            q.rdata <= RST_RDATA;
        end
        else if (i_ce)
            q <= d;
    end

    assign o_rdata     = q.rdata;
    assign o_timer_out = q.out;
    assign o_adc_trig  = q.adc_trig;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n || !i_ce);

    property p_dec;
        (q.mode[0] == MODE0 && q.run[0] && !q.load_pend[0] && tick[0]
         && gate_lvl[0] && !q.bcd[0] && !i_wr)
        |=> q.ce[0] == $past(q.ce[0]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec) else $error("no decrement");

    property p_ext_clk;
        (i_clk0_ext_sel && tick[0])
        |-> !$past(i_ext_clk0, 2) && $past(i_ext_clk0, 3);
    endproperty
    a_ext_clk: assert property (p_ext_clk) else $error("bad clk0");

    property p_int_clk;
        tick[1] == int_tick;
    endproperty
    a_int_clk: assert property (p_int_clk) else $error("bad clk1");

    property p_cascade;
        tick[2] |-> $past(q.out[1]) && !q.out[1];
    endproperty
    a_cascade: assert property (p_cascade) else $error("bad clk2");

    property p_mode0_cw;
        (i_wr && i_addr == OFS_CTRL && i_wdata[7:4] == 4'h3
         && i_wdata[3:1] == 3'h0)
        |=> q.mode[0] == MODE0 && !q.out[0] && !q.run[0];
    endproperty
    a_mode0_cw: assert property (p_mode0_cw) else $error("bad cw");

    property p_lsb_wr;
        (i_wr && i_addr == OFS_CNT1 && q.rwm[1] == RW_LSB)
        |=> q.cr[1] == {8'h00, $past(i_wdata)} && q.load_pend[1];
    endproperty
    a_lsb_wr: assert property (p_lsb_wr) else $error("bad write");

    property p_reload;
        (q.mode[1] == MODE2 && q.run[1] && tick[1] && gate_lvl[1]
         && q.ce[1] == 16'h0001 && !q.load_pend[1] && !q.trig[1] && !i_wr)
        |=> q.ce[1] == $past(q.cr[1]) && q.out[1];
    endproperty
    a_reload: assert property (p_reload) else $error("no reload");

    property p_gate_hold;
        (q.mode[1] == MODE2 && !gate_lvl[1] && !q.load_pend[1]
         && !q.trig[1] && !i_wr)
        |=> $stable(q.ce[1]) && q.out[1];
    endproperty
    a_gate_hold: assert property (p_gate_hold) else $error("gate");

    property p_trig_src;
        o_adc_trig |-> $past(i_pacer_int_sel)
                       && $past(q.out_prev[2]) && !$past(q.out[2]);
    endproperty
    a_trig_src: assert property (p_trig_src) else $error("bad trig");

    property p_ctrl_rd;
        (i_rd && i_addr == OFS_CTRL) |=> o_rdata == CTRL_READ;
    endproperty
    a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl read");

    c_adc_trig: cover property (o_adc_trig);
    c_out0:     cover property ($rose(q.out[0]) && q.mode[0] == MODE0);
    c_square:   cover property (q.mode[2] == MODE3 && $fell(q.out[2]));
    c_oneshot:  cover property (q.mode[0] == MODE1 && $rose(q.out[0]));
endmodule
`default_nettype wire

//--- test/connector_model.sv
// Connector side model: external clock and gate pins of the counters
`timescale 1ns/10ps
`default_nettype none
module connector_model
(
    input  wire logic       i_clk,
    input  wire logic [2:0] i_timer_out,
    output logic            o_ext_clk,
    output logic [2:0]      o_gate
);
    initial
    begin
        o_ext_clk = 1'b1;
        o_gate    = 3'h7;
    end
    // Bursts at 5 MHz, idle high so no stray tick
    task automatic burst(input int n);
        repeat (n)
        begin
            repeat (5) @(negedge i_clk);
            o_ext_clk = 1'b0;
            repeat (5) @(negedge i_clk);
            o_ext_clk = 1'b1;
        end
    endtask
    // Gates are plain pins, moved off the sampling edge
    task automatic set_gate(input logic [2:0] g);
        @(negedge i_clk);
        o_gate = g;
    endtask
endmodule
`default_nettype wire

//--- test/test_triple_counter_pacer.sv
// Self-checking bench for the triple counter pacer
`timescale 1ns/10ps
`default_nettype none
module test_triple_counter_pacer
    import tcp_pkg::*;
;
    logic       clk;
    logic       rst_n;
    logic [1:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wdata;
    logic       ext_sel;
    logic       int_sel;
    logic       ce;
    wire  [7:0] rdata;
    wire  [2:0] tout;
    wire        trig;
    wire        ext_clk;
    wire  [2:0] gate;
    wire  [3:0] mon;
    int         fail_count;
    int         check_count;
    int         c;
    assign mon = {trig, ~tout};
    initial clk = 1'b0;
    always #(CLK_PERIOD_NS / 2) clk = ~clk;
    triple_counter_pacer triple_counter_pacer_i (
        .i_clk(clk), .i_rst_n(rst_n), .i_ce(ce), .i_addr(addr),
        .i_wr(wr_en), .i_rd(rd_en), .i_wdata(wdata), .o_rdata(rdata),
        .i_clk0_ext_sel(ext_sel), .i_ext_clk0(ext_clk), .i_gate(gate),
        .i_pacer_int_sel(int_sel), .o_timer_out(tout), .o_adc_trig(trig));
    connector_model connector_model_i (
        .i_clk(clk), .i_timer_out(tout), .o_ext_clk(ext_clk),
        .o_gate(gate));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen_v, input logic [15:0] exp_v);
        check_count++;
        if (seen_v !== exp_v)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen_v, exp_v);
        end
    endtask
    task automatic bus_write(input logic [1:0] a, input logic [7:0] d);
        @(negedge clk);
        addr  = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
    endtask
    // Extra cycle before sampling: data stands until the next read
    task automatic bus_read(input logic [1:0] a, input logic [7:0] e);
        @(negedge clk);
        addr  = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        @(negedge clk);
        check(16'(rdata), 16'(e));
    endtask
    task automatic count_rise(input int k, input int cyc, output int n);
        logic p;
        n = 0;
        p = mon[k];
        repeat (cyc)
        begin
            @(negedge clk);
            if (p === 1'b0 && mon[k] === 1'b1)
                n++;
            p = mon[k];
        end
    endtask
    task automatic wait_rise(input int k, output int n);
        logic p;
        p = mon[k];
        for (n = 1; n <= 2000; n++)
        begin
            @(negedge clk);
            if (p === 1'b0 && mon[k] === 1'b1)
                return;
            p = mon[k];
        end
        fail_count++;
        tally_and_finish();
    endtask
    // Cycles between two successive pulses of one monitored signal
    task automatic period(input int k, input int e);
        int n;
        wait_rise(k, n);
        wait_rise(k, n);
        check(16'(n), 16'(e));
    endtask
    task automatic load(input logic [1:0] a, input logic [7:0] cw,
                        input logic [7:0] lo, input logic [7:0] hi);
        bus_write(OFS_CTRL, cw);
        bus_write(a, lo);
        bus_write(a, hi);
    endtask
    initial
    begin
        rst_n = 1'b0;
        addr = 2'h0;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
        ext_sel = 1'b0;
        int_sel = 1'b1;
        ce = 1'b1;
        fail_count = 0;
        check_count = 0;
        repeat (3) @(negedge clk);
        check(16'({rdata, tout, trig}), 16'h0000);
        rst_n = 1'b1;
        for (int m = 1; m < 6; m++)
        begin
            bus_write(OFS_CTRL, 8'h30 | 8'(m << 1));
            check(16'(tout[0]), 16'h0001);
        end
        connector_model_i.set_gate(3'h6);
        load(OFS_CNT0, 8'h30, 8'h34, 8'h12);
        check(16'(tout[0]), 16'h0000);
        repeat (100) @(negedge clk);
        bus_read(OFS_CNT0, 8'h34);
        bus_read(OFS_CNT0, 8'h12);
        bus_read(OFS_CTRL, CTRL_READ);
        connector_model_i.set_gate(3'h7);
        // Let mode 0 count down a few ticks with the gate open
        repeat (60) @(negedge clk);
        load(OFS_CNT0, 8'h34, 8'h04, 8'h00);
        period(0, 4 * INT_DIV);
        connector_model_i.set_gate(3'h6);
        count_rise(0, 200, c);
        check(16'(c), 16'h0000);
        check(16'(tout[0]), 16'h0001);
        connector_model_i.set_gate(3'h7);
        ext_sel = 1'b1;
        load(OFS_CNT0, 8'h34, 8'h03, 8'h00);
        fork
            connector_model_i.burst(12);
            period(0, 3 * 2 * 5);
        join
        count_rise(0, 100, c);
        check(16'(c), 16'h0000);
        ext_sel = 1'b0;
        bus_write(OFS_CTRL, 8'h52);
        bus_write(OFS_CNT1, 8'h5A);
        // Smallest legal pacer ratio: two per stage
        load(OFS_CNT1, 8'h74, 8'h02, 8'h00);
        load(OFS_CNT2, 8'hB4, 8'h02, 8'h00);
        period(1, 2 * INT_DIV);
        period(2, 4 * INT_DIV);
        period(3, 4 * INT_DIV);
        @(negedge clk);
        int_sel = 1'b0;
        count_rise(3, 300, c);
        check(16'(c), 16'h0000);
        int_sel = 1'b1;
        period(3, 4 * INT_DIV);
        connector_model_i.set_gate(3'h5);
        count_rise(3, 300, c);
        check(16'(c), 16'h0000);
        connector_model_i.set_gate(3'h7);
        period(3, 4 * INT_DIV);
        // Stop away from a trigger pulse so nothing freezes mid-edge
        repeat (10) @(negedge clk);
        ce = 1'b0;
        count_rise(1, 200, c);
        check(16'(c), 16'h0000);
        count_rise(3, 200, c);
        check(16'(c), 16'h0000);
        ce = 1'b1;
        period(3, 4 * INT_DIV);
        tally_and_finish();
    end
endmodule
`default_nettype wire
